// File: hw/tpc_map.svh
// Purpose: Register offsets, field positions and reset values of the PWM core.
// Assumes: Byte offsets on a 32-bit classic Wishbone bus, data in bits 7:0.
// Notes: Definitions only.
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH
// Byte offsets of the registers.
`define TPC_OFS_CONTROL 6'h00
`define TPC_OFS_REPEAT 6'h04
`define TPC_OFS_C_HIGH 6'h08
`define TPC_OFS_C_LOW 6'h0c
`define TPC_OFS_B_HIGH 6'h10
`define TPC_OFS_B_LOW 6'h14
`define TPC_OFS_A_HIGH 6'h18
`define TPC_OFS_A_LOW 6'h1c
`define TPC_OFS_P_HIGH 6'h20
`define TPC_OFS_P_LOW 6'h24
`define TPC_OFS_ENABLE 6'h28
`define TPC_OFS_MARKED 6'h2c
`define TPC_OFS_PHSTATE 6'h30
`define TPC_OFS_STATUS 6'h34
// Control register fields.
`define TPC_CTL_MODE8 7
`define TPC_CTL_FD_A 6
`define TPC_CTL_FD_B 5
`define TPC_CTL_FD_C 4
`define TPC_CTL_ALIGN 3
// Enable register fields.
`define TPC_EN_CLK 0
`define TPC_EN_DIRECT 1
// Writable masks and reset values.
`define TPC_LOW_MASK 8'hf8
`define TPC_PHIGH_MASK 8'h0f
`define TPC_RST_ZERO 8'h00
`define TPC_RST_PHIGH 8'h0f
`define TPC_RST_PLOW 8'hff
`endif

// File: hw/tpc_pkg.sv
// Purpose: Types shared by the PWM core and its users.
// Assumes: Nothing beyond the map header.
// Notes: Constants live in the map header, types live here.
package tpc_pkg;
	// Counter direction, one-hot.
	typedef enum logic [1:0] {
		TPC_UP = 2'b01,
		TPC_DOWN = 2'b10
	} tpc_dir_t;
	// One compare preload pair.
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} tpc_cmp_t;
	// The three phase outputs.
	typedef struct packed {
		logic a;
		logic b;
		logic c;
	} tpc_phase_t;
endpackage

// File: hw/tpc_top.sv
// Purpose: Three-phase PWM compare core with Wishbone register access.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Dead time, polarity and output management are outside this block.
// Functional notes
// R1 - Standard mode: high bit 7 extends compare.
// R2 - Eight-bit mode: extension from control, bits 15:8.
// R3 - Full-duty bit forces 100% for one update.
// R4 - Full-duty bits self-clear on transfer.
// R5 - Align bit selects edge or center counting.
// R6 - Prescaler divides clock by code plus one.
// R7 - Repetition zero: update, event, reload.
// R8 - First clock enable loads repetition, raises update.
// R9 - New repetition value applies after next update.
// R10 - Update every N+1 periods or half periods.
// R11 - Phase low bits 2:0 reserved, unwritable.
// R12 - Period preload 12 bits, resets all ones.
// R13 - Both halves written before update takes them.
// R14 - Marked bits load on commutation or direct write.
// R15 - Control, repetition, phase preloads reset zero.
// R16 - Reserved bits ignore writes, read reset value.
// R17 - Phase active below compare; period bounds counter.
`include "tpc_map.svh"
module tpc_top (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Commutation event pin, asynchronous.
	input wire logic commutate_i,
	// Block outputs.
	output tpc_pkg::tpc_phase_t phase_o,
	output logic update_o,
	output logic [3:0] marked_o
);
	// Bus decode.
	wire req = cyc_i & stb_i & ~ack_o;
	wire wr = req & we_i & sel_i[0];
	wire [7:0] wd = dat_i[7:0];
	wire wr_ctl = wr & (adr_i == `TPC_OFS_CONTROL);
	wire wr_rep = wr & (adr_i == `TPC_OFS_REPEAT);
	wire wr_en = wr & (adr_i == `TPC_OFS_ENABLE);
	wire wr_mk = wr & (adr_i == `TPC_OFS_MARKED);
	wire wr_ph = wr & (adr_i == `TPC_OFS_PHSTATE);
	// High and low write strobes per compare: a, b, c, period.
	wire [3:0] wr_hi = {wr & (adr_i == `TPC_OFS_A_HIGH),
		wr & (adr_i == `TPC_OFS_B_HIGH),
		wr & (adr_i == `TPC_OFS_C_HIGH),
		wr & (adr_i == `TPC_OFS_P_HIGH)};
	wire [3:0] wr_lo = {wr & (adr_i == `TPC_OFS_A_LOW),
		wr & (adr_i == `TPC_OFS_B_LOW),
		wr & (adr_i == `TPC_OFS_C_LOW),
		wr & (adr_i == `TPC_OFS_P_LOW)};

	// Registers.
	logic [7:0] ctl_q; // Control register.
	logic [7:0] rep_pre_q; // Repetition preload.
	logic [7:0] rep_act_q; // Repetition active value.
	logic [7:0] rep_cnt_q; // Repetition down-counter.
	logic [1:0] en_q; // Clock enable and direct access.
	logic en_prev_q; // Enable one cycle ago.
	logic first_done_q; // First enable has been seen.
	tpc_pkg::tpc_cmp_t pre_q [4]; // Preloads a, b, c, period.
	tpc_pkg::tpc_cmp_t act_q [4]; // Active compares.
	logic [3:0] hi_seen_q; // High half written since last load.
	logic [3:0] lo_seen_q; // Low half written since last load.
	logic [2:0] fd_act_q; // Active full-duty bits a, b, c.
	logic [3:0] mk_pre_q; // Marked bits preload.
	logic [3:0] mk_act_q; // Marked bits active.
	logic [2:0] cpre_q; // Prescaler count.
	logic [11:0] cnt_q; // PWM counter.
	tpc_pkg::tpc_dir_t dir_q; // Counter direction.
	logic [2:0] com_q; // Commutation synchroniser and edge flop.

	// Compare decode: returns {force, 12-bit threshold}.
	function automatic logic [12:0] cmp_dec(input tpc_pkg::tpc_cmp_t c,
		input logic mode8, input logic fd);
		logic [12:0] r;
		r = 13'h0000;
		if (mode8) begin
			r = {fd, c.high, 4'h0}; // [R2]
		end else begin
			r = {fd | c.high[7], c.high[6:0], c.low[7:3]}; // [R1] [R3]
		end
		return r;
	endfunction

	// Counter timing.
	wire en = en_q[`TPC_EN_CLK];
	wire tick = en & (cpre_q == ctl_q[2:0]); // [R6]
	wire [11:0] period = {act_q[0].high[3:0], act_q[0].low};
	wire at_top = tick & (cnt_q == period);
	wire at_bot = tick & (cnt_q == 12'h000);
	wire center = ctl_q[`TPC_CTL_ALIGN];
	// Period event in edge mode, half-period event in center mode.
	wire evt = center ? ((dir_q == tpc_pkg::TPC_UP) ? at_top :
		(at_bot & dir_q == tpc_pkg::TPC_DOWN)) : at_top; // [R5] [R10]
	wire first_en = en & ~en_prev_q & ~first_done_q; // [R8]
	wire upd = first_en | (evt & (rep_cnt_q == 8'h00)); // [R7] [R10]
	// Compares load only when both halves have been written.
	wire [3:0] load = {4{upd}} & hi_seen_q & lo_seen_q; // [R13]
	wire com_evt = com_q[1] & ~com_q[2];
	wire mk_load = en_q[`TPC_EN_DIRECT] ? wr_ph : com_evt; // [R14]

	// Thresholds for the three phases.
	wire [12:0] dec_a = cmp_dec(act_q[3], ctl_q[`TPC_CTL_MODE8], fd_act_q[2]);
	wire [12:0] dec_b = cmp_dec(act_q[2], ctl_q[`TPC_CTL_MODE8], fd_act_q[1]);
	wire [12:0] dec_c = cmp_dec(act_q[1], ctl_q[`TPC_CTL_MODE8], fd_act_q[0]);

	// Read mux; unmapped offsets read zero.
	logic [7:0] rd;
	always_comb begin
		case (adr_i)
			`TPC_OFS_CONTROL: rd = ctl_q;
			`TPC_OFS_REPEAT: rd = rep_pre_q;
			`TPC_OFS_A_HIGH: rd = pre_q[3].high;
			`TPC_OFS_A_LOW: rd = pre_q[3].low;
			`TPC_OFS_B_HIGH: rd = pre_q[2].high;
			`TPC_OFS_B_LOW: rd = pre_q[2].low;
			`TPC_OFS_C_HIGH: rd = pre_q[1].high;
			`TPC_OFS_C_LOW: rd = pre_q[1].low;
			`TPC_OFS_P_HIGH: rd = pre_q[0].high;
			`TPC_OFS_P_LOW: rd = pre_q[0].low;
			`TPC_OFS_ENABLE: rd = {6'h00, en_q};
			`TPC_OFS_MARKED: rd = {4'h0, mk_pre_q};
			`TPC_OFS_PHSTATE: rd = {4'h0, mk_act_q};
			`TPC_OFS_STATUS: rd = {dir_q == tpc_pkg::TPC_DOWN, 3'h0,
				fd_act_q, first_done_q};
			default: rd = 8'h00;
		endcase
	end

	// Bus answer: one ack per request, one cycle after it is seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			dat_o <= req ? {24'h000000, rd} : 32'h0000_0000;
		end
	end

	// Control register; a write of a full-duty bit beats the self-clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_q <= `TPC_RST_ZERO; // [R15]
		end else if (wr_ctl) begin
			ctl_q <= wd;
		end else if (upd) begin
			ctl_q[6:4] <= 3'h0; // [R4]
		end
	end

	// Repetition preload, active value and down-counter.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rep_pre_q <= `TPC_RST_ZERO; // [R15]
			rep_act_q <= `TPC_RST_ZERO;
			rep_cnt_q <= `TPC_RST_ZERO;
		end else begin
			if (wr_rep) begin
				rep_pre_q <= wd;
			end
			if (upd) begin
				rep_act_q <= rep_pre_q; // [R8] [R9]
				rep_cnt_q <= rep_pre_q; // [R7]
			end else if (evt) begin
				rep_cnt_q <= rep_cnt_q - 8'h01; // [R10]
			end
		end
	end

	// Enable register and first-enable tracking.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_q <= 2'b00;
			en_prev_q <= 1'b0;
			first_done_q <= 1'b0;
		end else begin
			if (wr_en) begin
				en_q <= wd[1:0];
			end
			en_prev_q <= en;
			if (first_en) begin
				first_done_q <= 1'b1; // [R8]
			end
		end
	end

	// Compare preloads, write tracking and active copies.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 1; i < 4; i++) begin
				pre_q[i] <= '{`TPC_RST_ZERO, `TPC_RST_ZERO}; // [R15]
				act_q[i] <= '{`TPC_RST_ZERO, `TPC_RST_ZERO};
			end
			pre_q[0] <= '{`TPC_RST_PHIGH, `TPC_RST_PLOW}; // [R12]
			act_q[0] <= '{`TPC_RST_PHIGH, `TPC_RST_PLOW};
			hi_seen_q <= 4'h0;
			lo_seen_q <= 4'h0;
			fd_act_q <= 3'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_hi[i]) begin
					// Reserved period high bits keep their reset value.
					pre_q[i].high <= (i == 0) ?
						((wd & `TPC_PHIGH_MASK) | (`TPC_RST_PHIGH &
						~`TPC_PHIGH_MASK)) : wd; // [R12] [R16]
				end
				if (wr_lo[i]) begin
					pre_q[i].low <= (i == 0) ? wd :
						(wd & `TPC_LOW_MASK); // [R11] [R16]
				end
				if (load[i]) begin
					act_q[i] <= pre_q[i]; // [R13]
				end
				// A write in the load cycle stays pending.
				hi_seen_q[i] <= wr_hi[i] | (hi_seen_q[i] & ~load[i]);
				lo_seen_q[i] <= wr_lo[i] | (lo_seen_q[i] & ~load[i]);
			end
			if (upd) begin
				fd_act_q <= ctl_q[6:4]; // [R3] [R4]
			end
		end
	end

	// Marked bits and commutation synchroniser.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mk_pre_q <= 4'h0;
			mk_act_q <= 4'h0;
			com_q <= 3'h0;
		end else begin
			com_q <= {com_q[1:0], commutate_i};
			if (wr_mk) begin
				mk_pre_q <= wd[3:0];
			end
			if (mk_load) begin
				mk_act_q <= mk_pre_q; // [R14]
			end
		end
	end

	// Prescaler and counter; stopped and cleared while disabled.
	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			cpre_q <= 3'h0;
			cnt_q <= 12'h000;
			dir_q <= tpc_pkg::TPC_UP;
		end else begin
			cpre_q <= tick ? 3'h0 : cpre_q + 3'h1; // [R6]
			if (tick) begin
				case (dir_q)
					tpc_pkg::TPC_UP: begin
						if (cnt_q == period) begin
							// Edge mode wraps, center mode turns.
							cnt_q <= center ? cnt_q - 12'h001 :
								12'h000; // [R5] [R17]
							if (center && period != 12'h000) begin
								dir_q <= tpc_pkg::TPC_DOWN;
							end
						end else begin
							cnt_q <= cnt_q + 12'h001;
						end
					end
					tpc_pkg::TPC_DOWN: begin
						if (cnt_q == 12'h000) begin
							cnt_q <= 12'h001;
							dir_q <= tpc_pkg::TPC_UP;
						end else begin
							cnt_q <= cnt_q - 12'h001;
						end
					end
					default: dir_q <= tpc_pkg::TPC_UP;
				endcase
			end
		end
	end

	// Outputs, each from a flip-flop.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_o <= '0;
			update_o <= 1'b0;
			marked_o <= 4'h0;
		end else begin
			phase_o.a <= en & (dec_a[12] | cnt_q < dec_a[11:0]); // [R17]
			phase_o.b <= en & (dec_b[12] | cnt_q < dec_b[11:0]);
			phase_o.c <= en & (dec_c[12] | cnt_q < dec_c[11:0]);
			update_o <= upd; // [R7]
			marked_o <= mk_act_q;
		end
	end

	// Checks.
	property p_fd_clear;
		@(posedge clk_i) disable iff (rst_i)
		(upd && !wr_ctl) |=> (ctl_q[6:4] == 3'h0);
	endproperty
	a_fd_clear: assert property (p_fd_clear) else $error("fd not cleared"); // [R4]

	property p_fd_force;
		@(posedge clk_i) disable iff (rst_i)
		(upd && ctl_q[6] && en) ##1 en |=> phase_o.a;
	endproperty
	a_fd_force: assert property (p_fd_force) else $error("no full duty"); // [R3]

	property p_rep_zero;
		@(posedge clk_i) disable iff (rst_i)
		(evt && rep_cnt_q == 8'h00) |=> update_o && rep_cnt_q == rep_act_q;
	endproperty
	a_rep_zero: assert property (p_rep_zero) else $error("no update"); // [R7]

	property p_first;
		@(posedge clk_i) disable iff (rst_i)
		(en && !en_prev_q && !first_done_q) |=> update_o && first_done_q;
	endproperty
	a_first: assert property (p_first) else $error("no first update"); // [R8]

	property p_rep_hold;
		@(posedge clk_i) disable iff (rst_i)
		!upd |=> $stable(rep_act_q);
	endproperty
	a_rep_hold: assert property (p_rep_hold) else $error("early rep"); // [R9]

	property p_act_hold;
		@(posedge clk_i) disable iff (rst_i)
		!upd |=> $stable(act_q[3]) && $stable(act_q[0]);
	endproperty
	a_act_hold: assert property (p_act_hold) else $error("early load"); // [R13]

	sequence s_top;
		center && dir_q == tpc_pkg::TPC_UP && at_top && period != 12'h000;
	endsequence
	property p_turn;
		@(posedge clk_i) disable iff (rst_i)
		s_top |=> (dir_q == tpc_pkg::TPC_DOWN) || !en;
	endproperty
	a_turn: assert property (p_turn) else $error("no turn"); // [R5]

	property p_pre;
		@(posedge clk_i) disable iff (rst_i)
		(tick && ctl_q[2:0] == 3'h2 && !wr_ctl && !wr_en) |=>
			!tick ##1 (!tick || wr_ctl || wr_en);
	endproperty
	a_pre: assert property (p_pre) else $error("prescale wrong"); // [R6]

	property p_low_rsv;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> pre_q[3].low[2:0] == 3'h0 && pre_q[0].high[7:4] == 4'h0;
	endproperty
	a_low_rsv: assert property (p_low_rsv) else $error("rsv bits"); // [R11] [R16]

	property p_direct;
		@(posedge clk_i) disable iff (rst_i)
		(wr_ph && en_q[`TPC_EN_DIRECT]) |=> mk_act_q == $past(mk_pre_q);
	endproperty
	a_direct: assert property (p_direct) else $error("direct load"); // [R14]

	// In normal mode a commutation edge copies the marked preload.
	property p_com_load;
		@(posedge clk_i) disable iff (rst_i)
		(com_evt && !en_q[`TPC_EN_DIRECT]) |=> mk_act_q == $past(mk_pre_q);
	endproperty
	a_com_load: assert property (p_com_load) else $error("com load"); // [R14]

	// Without a load event the active marked bits never move.
	property p_mk_hold;
		@(posedge clk_i) disable iff (rst_i)
		!mk_load |=> $stable(mk_act_q);
	endproperty
	a_mk_hold: assert property (p_mk_hold) else $error("marked moved"); // [R14]
endmodule

// File: sim/tpc_tb_top.sv
// Purpose: Self-checking bench for the three-phase PWM compare core.
// Assumes: The register map header and one 100 MHz clock.
// Notes: Update spacing is predicted by a small integer model.
`include "tpc_map.svh"
module three_phase_pwm_compare_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Bus and block signals; the bench drives the commutation pin as well.
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [5:0] adr_i = 6'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic update_o;
	logic commutate_i = 1'b0;
	logic [3:0] marked_o;
	tpc_pkg::tpc_phase_t phase_o;
	// Counters; the random source starts at 26003.
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	logic [15:0] lfsr_q = 16'h6593;
	// Reset values of offsets 00 to 24, one entry per register.
	logic [7:0] exp_rst [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h0f, 8'hff};

	// Counts a compare and reports a mismatch at once.
	`define CHK(nm, ex, got) begin \
		checked++; \
		if ((got) !== (ex)) begin \
			fail_count++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
		end \
	end

	tpc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.commutate_i(commutate_i), .phase_o(phase_o),
		.update_o(update_o), .marked_o(marked_o));

	// Free-running clock at 10 ns.
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// A hang is cut short well beyond the expected run length.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 50000) begin
			fail_count++;
			wrap_up();
		end
	end

	// Galois-free shift register step, taps for a maximal 16-bit run.
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Cycles between updates: repeats times counts per period times divisor.
	function automatic int spacing(int rep, int per, int dv, bit ctr);
		return (rep + 1) * (ctr ? per : per + 1) * dv;
	endfunction

	// Active samples in eight cycles of an edge count from 0 to 3.
	// A phase is active while the count is below its threshold.
	function automatic int duty(int thr, bit full);
		return full ? 8 : 2 * ((thr < 4) ? thr : 4);
	endfunction

	// Counts the active samples of phases b and c over eight edges.
	task automatic cnt_hi(output int nb, output int nc);
		nb = 0;
		nc = 0;
		repeat (8) begin
			@(posedge clk_i);
			if (phase_o.b === 1'b1) begin
				nb++;
			end
			if (phase_o.c === 1'b1) begin
				nc++;
			end
		end
	endtask

	// One classic cycle; request held until ack is sampled high.
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] ex, string nm);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		`CHK(nm, ex, q)
	endtask

	// Counts edges up to and including the next update pulse.
	task automatic wait_upd(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (update_o !== 1'b1);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence.
	initial begin
		int n;
		int rep;
		int nb;
		int nc;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			rd(6'(i * 4), exp_rst[i], "reset value");
		end
		// Unmapped space answers with zero.
		rd(6'h3c, 8'h00, "unmapped");
		// Reserved bits keep their reset value.
		wr(`TPC_OFS_A_LOW, 8'hff);
		rd(`TPC_OFS_A_LOW, 8'hf8, "phase low");
		wr(`TPC_OFS_P_HIGH, 8'hff);
		rd(`TPC_OFS_P_HIGH, 8'h0f, "period high");
		// A short period, both halves written before the first update.
		wr(`TPC_OFS_P_HIGH, 8'h00);
		wr(`TPC_OFS_P_LOW, 8'h03);
		wr(`TPC_OFS_ENABLE, 8'h01);
		wait_upd(n);
		`CHK("first update", 1'b1, n < 8)
		// Status shows the first enable seen, counting up, no full duty.
		rd(`TPC_OFS_STATUS, 8'h01, "status after first update");
		// Every prescale code, with a random repetition value each time.
		for (int code = 0; code < 8; code++) begin
			lfsr_q = nxt(lfsr_q);
			rep = int'(lfsr_q[1:0]);
			wr(`TPC_OFS_CONTROL, 8'(code));
			wr(`TPC_OFS_REPEAT, 8'(rep));
			// The first update only loads the new repetition value.
			wait_upd(n);
			wait_upd(n);
			wait_upd(n);
			`CHK("edge spacing", spacing(rep, 3, code + 1, 0), n)
		end
		// Center mode counts half periods.
		wr(`TPC_OFS_REPEAT, 8'h03);
		wr(`TPC_OFS_CONTROL, 8'h08);
		wait_upd(n);
		wait_upd(n);
		wait_upd(n);
		`CHK("center spacing", spacing(3, 3, 1, 1), n)
		// Full duty on phase a lasts one update interval.
		wr(`TPC_OFS_CONTROL, 8'h40);
		wait_upd(n);
		repeat (2) @(posedge clk_i);
		`CHK("phase a forced", 1'b1, phase_o.a)
		rd(`TPC_OFS_CONTROL, 8'h00, "full duty self clear");
		wait_upd(n);
		wait_upd(n);
		rd(`TPC_OFS_CONTROL, 8'h00, "full duty stays clear");
		`CHK("phase a released", 1'b0, phase_o.a)
		// A compare loads only once both of its halves are written.
		wr(`TPC_OFS_B_LOW, 8'h10);
		wait_upd(n);
		cnt_hi(nb, nc);
		`CHK("phase b low half only", duty(0, 0), nb)
		wr(`TPC_OFS_B_HIGH, 8'h00);
		wr(`TPC_OFS_C_HIGH, 8'h80);
		wr(`TPC_OFS_C_LOW, 8'h00);
		wait_upd(n);
		cnt_hi(nb, nc);
		`CHK("phase b duty", duty(2, 0), nb)
		`CHK("phase c extension bit", duty(0, 1), nc)
		// Eight-bit mode uses the high byte only, shifted up four bits.
		wr(`TPC_OFS_CONTROL, 8'h80);
		cnt_hi(nb, nc);
		`CHK("phase b eight bit", duty(0, 0), nb)
		`CHK("phase c eight bit", duty(12'h800, 0), nc)
		// In eight-bit mode the control bit is the extension.
		wr(`TPC_OFS_CONTROL, 8'ha0);
		wait_upd(n);
		cnt_hi(nb, nc);
		`CHK("phase b eight bit forced", duty(0, 1), nb)
		wait_upd(n);
		cnt_hi(nb, nc);
		`CHK("phase b forced ends", duty(0, 0), nb)
		// Marked bits wait for their load event.
		wr(`TPC_OFS_MARKED, 8'h05);
		`CHK("marked held", 4'h0, marked_o)
		wr(`TPC_OFS_ENABLE, 8'h03);
		wr(`TPC_OFS_PHSTATE, 8'h00);
		rd(`TPC_OFS_PHSTATE, 8'h05, "direct load");
		`CHK("marked direct", 4'h5, marked_o)
		// Normal mode: only a commutation edge loads them.
		wr(`TPC_OFS_ENABLE, 8'h01);
		wr(`TPC_OFS_MARKED, 8'h0a);
		`CHK("marked waits", 4'h5, marked_o)
		@(posedge clk_i);
		commutate_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		`CHK("marked on commutation", 4'ha, marked_o)
		commutate_i <= 1'b0;
		wrap_up();
	end
endmodule
